/* File: hw/cpu_status_flag_register.sv */
// Behaviour
// - carry flag is bit 7; arithmetic captures carry out of bit 7.
// - rotate and shift load carry with the last bit shifted out.
// - zero flag bit 6 set when arithmetic or logical result is zero.
// - sign flag bit 5 copies result msb after arithmetic, logical, shift.
// - decimal adjust bit 3 set after subtraction, cleared after addition.
// - half carry bit 2 marks carry out of, or borrow into, bit 3.
// - jump logic can test carry, overflow, zero and sign.
// - half carry and decimal adjust are never offered as jump conditions.
// - user flags bits 1 and 0 change only by explicit set or clear, or by a register write.
// - register at address 252, all bits read/write, reset value 0x00.
`timescale 1ns/10ps
module cpu_status_flag_register (
  input  wire logic                  clk_i,
  input  wire logic                  rstn_i,
  input  wire flag_pkg::alu_req_t    alu_i,
  output logic [7:0]                 result_o,
  output logic [7:0]                 flags_o,
  output flag_pkg::jump_cond_t       cond_o,
  input  wire logic [7:0]            awaddr_i,
  input  wire logic [2:0]            awprot_i,
  input  wire logic                  awvalid_i,
  output logic                       awready_o,
  input  wire logic [31:0]           wdata_i,
  input  wire logic [3:0]            wstrb_i,
  input  wire logic                  wvalid_i,
  output logic                       wready_o,
  output logic [1:0]                 bresp_o,
  output logic                       bvalid_o,
  input  wire logic                  bready_i,
  input  wire logic [7:0]            araddr_i,
  input  wire logic [2:0]            arprot_i,
  input  wire logic                  arvalid_i,
  output logic                       arready_o,
  output logic [31:0]                rdata_o,
  output logic [1:0]                 rresp_o,
  output logic                       rvalid_o,
  input  wire logic                  rready_i
);
  import flag_pkg::*;

  // write channel capture
  logic        aw_held;
  logic        w_held;
  logic [7:0]  waddr;
  logic [7:0]  wbyte;
  logic        wlane0;
  wire  logic  aw_hs         = awvalid_i & awready_o;
  wire  logic  w_hs          = wvalid_i & wready_o;
  wire  logic  do_write      = aw_held & w_held & ~bvalid_o;
  wire  logic  next_aw_held  = (aw_held | aw_hs) & ~do_write;
  wire  logic  next_w_held   = (w_held | w_hs) & ~do_write;
  wire  logic  next_bvalid   = do_write | (bvalid_o & ~bready_i);
  wire  logic  wr_hit        = waddr[7:2] == FLAGS_ADDR[7:2];
  wire  logic  wr_flags      = do_write & wr_hit & wlane0;

  // read channel
  wire  logic  ar_hs         = arvalid_i & arready_o;
  wire  logic  rd_hit        = araddr_i[7:2] == FLAGS_ADDR[7:2];
  wire  logic  next_rvalid   = ar_hs | (rvalid_o & ~rready_i);

  // arithmetic datapath
  wire  logic       cin      = alu_i.with_carry & flags_o[CARRY_BIT];
  wire  logic [8:0] sum9     = {1'b0, alu_i.a} + {1'b0, alu_i.b} + {8'h00, cin};
  wire  logic [8:0] dif9     = {1'b0, alu_i.a} - {1'b0, alu_i.b} - {8'h00, cin};
  wire  logic [4:0] sum_lo   = {1'b0, alu_i.a[3:0]} + {1'b0, alu_i.b[3:0]} + {4'h0, cin};
  wire  logic [4:0] dif_lo   = {1'b0, alu_i.a[3:0]} - {1'b0, alu_i.b[3:0]} - {4'h0, cin};
  wire  logic       add_ovf  = (alu_i.a[7] == alu_i.b[7]) & (sum9[7] != alu_i.a[7]);
  wire  logic       sub_ovf  = (alu_i.a[7] != alu_i.b[7]) & (dif9[7] != alu_i.a[7]);
  wire  logic       is_add   = alu_i.valid & (alu_i.op == OP_ADD);
  wire  logic       is_sub   = alu_i.valid & (alu_i.op == OP_SUB);
  wire  logic       is_logic = alu_i.valid & (alu_i.op == OP_LOGIC);
  wire  logic       is_shift = alu_i.valid & (alu_i.op == OP_SHIFT);
  wire  logic       is_user  = alu_i.valid & (alu_i.op == OP_USER);

  // per-bit explicit set or clear of the user flags
  wire  logic [1:0] next_user;
  for (genvar i = 0; i < 2; i++) begin : g_user
    assign next_user[i] = (is_user & alu_i.user_mask[i]) ?
                          alu_i.user_val[i] : flags_o[USER_ONE_BIT + i];
  end

  logic [7:0] next_flags;
  logic [7:0] next_result;

  always_comb begin
    next_flags  = flags_o;
    next_result = result_o;
    if (is_add) begin
      next_result           = sum9[7:0];
      next_flags[CARRY_BIT] = sum9[8];
      next_flags[ZERO_BIT]  = sum9[7:0] == 8'h00;
      next_flags[SIGN_BIT]  = sum9[7];
      next_flags[OVF_BIT]   = add_ovf;
      next_flags[DADJ_BIT]  = 1'b0;
      next_flags[HALF_BIT]  = sum_lo[4];
    end else if (is_sub) begin
      next_result           = dif9[7:0];
      next_flags[CARRY_BIT] = dif9[8];
      next_flags[ZERO_BIT]  = dif9[7:0] == 8'h00;
      next_flags[SIGN_BIT]  = dif9[7];
      next_flags[OVF_BIT]   = sub_ovf;
      next_flags[DADJ_BIT]  = 1'b1;
      next_flags[HALF_BIT]  = dif_lo[4];
    end else if (is_logic) begin
      next_result           = alu_i.a;
      next_flags[ZERO_BIT]  = alu_i.a == 8'h00;
      next_flags[SIGN_BIT]  = alu_i.a[7];
      next_flags[OVF_BIT]   = 1'b0;
    end else if (is_shift) begin
      next_result           = alu_i.a;
      next_flags[CARRY_BIT] = alu_i.shift_out;
      next_flags[SIGN_BIT]  = alu_i.a[7];
    end else if (is_user) begin
      // only explicit set or clear touches the user flags
      next_flags[USER_TWO_BIT:USER_ONE_BIT] = next_user;
    end
    // software write wins over a same-cycle cpu update
    if (wr_flags) begin
      next_flags = wbyte;
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      flags_o  <= FLAGS_RESET;
      result_o <= 8'h00;
    end else begin
      flags_o  <= next_flags;
      result_o <= next_result;
    end
  end

  // only carry, overflow, zero and sign leave as jump conditions
  assign cond_o = '{carry:    flags_o[CARRY_BIT],
                    overflow: flags_o[OVF_BIT],
                    zero:     flags_o[ZERO_BIT],
                    sign:     flags_o[SIGN_BIT]};

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      aw_held   <= 1'b0;
      w_held    <= 1'b0;
      awready_o <= 1'b1;
      wready_o  <= 1'b1;
      bvalid_o  <= 1'b0;
    end else begin
      aw_held   <= next_aw_held;
      w_held    <= next_w_held;
      awready_o <= ~next_aw_held;
      wready_o  <= ~next_w_held;
      bvalid_o  <= next_bvalid;
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      waddr   <= 8'h00;
      wbyte   <= 8'h00;
      wlane0  <= 1'b0;
      bresp_o <= RESP_OKAY;
    end else begin
      if (aw_hs) begin
        waddr <= awaddr_i;
      end
      if (w_hs) begin
        wbyte  <= wdata_i[7:0];
        wlane0 <= wstrb_i[0];
      end
      if (do_write) begin
        bresp_o <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      arready_o <= 1'b1;
      rvalid_o  <= 1'b0;
      rdata_o   <= 32'h0000_0000;
      rresp_o   <= RESP_OKAY;
    end else begin
      arready_o <= ~next_rvalid;
      rvalid_o  <= next_rvalid;
      if (ar_hs) begin
        rdata_o <= rd_hit ? {24'h00_0000, flags_o} : 32'h0000_0000;
        rresp_o <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end
    end
  end

  // checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);

  a_carry_arith: assert property (is_add && !wr_flags
    |=> flags_o[CARRY_BIT] == $past(sum9[8]) && result_o == $past(sum9[7:0]))
    else $error("carry not captured from add");

  a_carry_shift: assert property (is_shift && !wr_flags
    |=> flags_o[CARRY_BIT] == $past(alu_i.shift_out))
    else $error("carry not loaded from shift");

  a_zero_result: assert property ((is_add || is_sub || is_logic) && !wr_flags
    |=> flags_o[ZERO_BIT] == (result_o == 8'h00))
    else $error("zero flag does not match result");

  a_sign_msb: assert property ((alu_i.valid && alu_i.op != OP_USER
    && alu_i.op != OP_NONE) && !wr_flags |=> flags_o[SIGN_BIT] == result_o[7])
    else $error("sign flag does not match msb");

  a_ovf_sub: assert property (is_sub && !wr_flags
    |=> flags_o[OVF_BIT] == ($signed({$past(alu_i.a[7]), $past(alu_i.a)})
        - $signed({$past(alu_i.b[7]), $past(alu_i.b)})
        - $signed({1'b0, $past(cin)}) != $signed(result_o)))
    else $error("overflow flag wrong after subtract");

  a_dadj_kind: assert property ((is_add || is_sub) && !wr_flags
    |=> flags_o[DADJ_BIT] == $past(is_sub))
    else $error("decimal adjust flag wrong");

  a_half_add: assert property (is_add && !wr_flags
    |=> flags_o[HALF_BIT] == ($past({1'b0, alu_i.a[3:0]}) + $past({1'b0, alu_i.b[3:0]})
        + $past({4'h0, cin}) > 5'h0f))
    else $error("half carry wrong after add");

  a_jump_view: assert property (cond_o == {flags_o[7], flags_o[4],
    flags_o[6], flags_o[5]})
    else $error("jump conditions do not track flags");

  a_user_hold: assert property (!is_user && !wr_flags
    |=> $stable(flags_o[1:0]))
    else $error("user flags changed without request");

  a_read_back: assert property (ar_hs && rd_hit
    |=> rvalid_o && rdata_o == {24'h00_0000, $past(flags_o)})
    else $error("register read returned wrong value");

  a_write_lands: assert property (wr_flags |=> flags_o == $past(wbyte)
    ##1 bvalid_o || $past(bready_i))
    else $error("register write not stored");

  a_bvalid_hold: assert property (bvalid_o && !bready_i
    |=> bvalid_o && $stable(bresp_o))
    else $error("write response dropped early");

  // alu side
  a_ovf_add: assert property (is_add && !wr_flags
    |=> flags_o[OVF_BIT] == ($signed({$past(alu_i.a[7]), $past(alu_i.a)})
        + $signed({$past(alu_i.b[7]), $past(alu_i.b)})
        + $signed({1'b0, $past(cin)}) != $signed(result_o)))
    else $error("overflow flag wrong after add");

  a_carry_sub: assert property (is_sub && !wr_flags
    |=> flags_o[CARRY_BIT] == ($past({1'b0, alu_i.a})
        < $past({1'b0, alu_i.b}) + $past({8'h00, cin})))
    else $error("borrow not captured from subtract");

  a_half_sub: assert property (is_sub && !wr_flags
    |=> flags_o[HALF_BIT] == ($past({1'b0, alu_i.a[3:0]})
        < $past({1'b0, alu_i.b[3:0]}) + $past({4'h0, cin})))
    else $error("half carry wrong after subtract");

  a_add_result: assert property (is_add && !alu_i.with_carry
    |=> result_o == $past(alu_i.a + alu_i.b))
    else $error("add result wrong");

  a_sub_result: assert property (is_sub && !alu_i.with_carry
    |=> result_o == $past(alu_i.a - alu_i.b))
    else $error("subtract result wrong");

  a_pass_result: assert property ((is_logic || is_shift)
    |=> result_o == $past(alu_i.a))
    else $error("logic or shift result wrong");

  a_logic_keep: assert property (is_logic && !wr_flags
    |=> !flags_o[OVF_BIT] && $stable({flags_o[CARRY_BIT], flags_o[DADJ_BIT],
        flags_o[HALF_BIT], flags_o[USER_TWO_BIT:USER_ONE_BIT]}))
    else $error("logic op touched flags it must keep");

  a_shift_keep: assert property (is_shift && !wr_flags
    |=> $stable({flags_o[ZERO_BIT], flags_o[OVF_BIT], flags_o[DADJ_BIT],
        flags_o[HALF_BIT], flags_o[USER_TWO_BIT:USER_ONE_BIT]}))
    else $error("shift touched flags it must keep");

  a_user_only: assert property (is_user && !wr_flags
    |=> $stable(flags_o[CARRY_BIT:HALF_BIT]))
    else $error("user op touched status flags");

  a_user_one: assert property (is_user && alu_i.user_mask[0] && !wr_flags
    |=> flags_o[USER_ONE_BIT] == $past(alu_i.user_val[0]))
    else $error("first user flag not set as asked");

  a_user_two: assert property (is_user && alu_i.user_mask[1] && !wr_flags
    |=> flags_o[USER_TWO_BIT] == $past(alu_i.user_val[1]))
    else $error("second user flag not set as asked");

  a_idle_hold: assert property (!alu_i.valid && !wr_flags
    |=> $stable(flags_o) && $stable(result_o))
    else $error("flags changed with no request");

  a_jump_free: assert property ($stable({flags_o[CARRY_BIT], flags_o[OVF_BIT],
    flags_o[ZERO_BIT], flags_o[SIGN_BIT]}) |-> $stable(cond_o))
    else $error("jump conditions moved with other flags");

  // bus side
  a_write_refused: assert property (do_write && !wr_flags && !alu_i.valid
    |=> $stable(flags_o))
    else $error("refused write changed the flags");

  a_write_resp: assert property (do_write
    |=> bvalid_o && (bresp_o == RESP_OKAY) == ($past(waddr[7:2]) == FLAGS_ADDR[7:2]))
    else $error("write response wrong");

  a_no_early_resp: assert property (!do_write && !bvalid_o
    |=> !bvalid_o)
    else $error("write response without a write");

  a_aw_taken: assert property (aw_hs
    |=> !awready_o)
    else $error("write address accepted twice");

  a_w_taken: assert property (w_hs
    |=> !wready_o)
    else $error("write data accepted twice");

  a_read_miss: assert property (ar_hs && !rd_hit
    |=> rvalid_o && rdata_o == 32'h0000_0000 && rresp_o == RESP_SLVERR)
    else $error("unmapped read not refused");

  a_rvalid_hold: assert property (rvalid_o && !rready_i
    |=> rvalid_o && $stable(rdata_o) && $stable(rresp_o))
    else $error("read data dropped early");

  a_read_single: assert property (rvalid_o
    |-> !arready_o)
    else $error("second read accepted while one is pending");

  a_no_early_read: assert property (!ar_hs && !rvalid_o
    |=> !rvalid_o)
    else $error("read data without a read");

  c_add_carry: cover property (is_add ##1 flags_o[CARRY_BIT]);
  c_sub_borrow: cover property (is_sub ##1 flags_o[HALF_BIT]);
  c_shift_op: cover property (is_shift ##1 cond_o.carry);
  c_bus_clash: cover property (wr_flags && alu_i.valid);
  c_user_set: cover property (is_user ##1 flags_o[USER_ONE_BIT]);

endmodule

/* File: hw/flag_pkg.sv */
package flag_pkg;

  localparam logic [7:0]  FLAGS_ADDR   = 8'hfc;
  localparam logic [7:0]  FLAGS_RESET  = 8'h00;
  localparam int          CARRY_BIT    = 7;
  localparam int          ZERO_BIT     = 6;
  localparam int          SIGN_BIT     = 5;
  localparam int          OVF_BIT      = 4;
  localparam int          DADJ_BIT     = 3;
  localparam int          HALF_BIT     = 2;
  localparam int          USER_TWO_BIT = 1;
  localparam int          USER_ONE_BIT = 0;
  localparam logic [1:0]  RESP_OKAY    = 2'h0;
  localparam logic [1:0]  RESP_SLVERR  = 2'h2;

  typedef enum logic [2:0] {
    OP_NONE  = 3'h0,
    OP_ADD   = 3'h1,
    OP_SUB   = 3'h3,
    OP_LOGIC = 3'h2,
    OP_SHIFT = 3'h6,
    OP_USER  = 3'h7
  } alu_op_t;

  typedef struct packed {
    logic       valid;
    alu_op_t    op;
    logic       with_carry;
    logic [7:0] a;
    logic [7:0] b;
    logic       shift_out;
    logic [1:0] user_mask;
    logic [1:0] user_val;
  } alu_req_t;

  typedef struct packed {
    logic carry;
    logic overflow;
    logic zero;
    logic sign;
  } jump_cond_t;

endpackage

/* File: verif/tb_top.sv */
`timescale 1ns/10ps
module tb_top;
  import flag_pkg::*;
  logic        clk_i, rstn_i, awvalid_i, wvalid_i, bready_i, arvalid_i, rready_i;
  alu_req_t    alu_i;
  logic [7:0]  awaddr_i, araddr_i, result_o, flags_o;
  logic [31:0] wdata_i, rdata_o, rd;
  logic [3:0]  wstrb_i;
  logic [1:0]  bresp_o, rresp_o, rs;
  logic        awready_o, wready_o, bvalid_o, arready_o, rvalid_o;
  jump_cond_t  cond_o;
  int          errors, cmp_count;

  cpu_status_flag_register u_dut (.clk_i(clk_i), .rstn_i(rstn_i), .alu_i(alu_i),
    .result_o(result_o), .flags_o(flags_o), .cond_o(cond_o), .awaddr_i(awaddr_i),
    .awprot_i(3'h0), .awvalid_i(awvalid_i), .awready_o(awready_o), .wdata_i(wdata_i),
    .wstrb_i(wstrb_i), .wvalid_i(wvalid_i), .wready_o(wready_o), .bresp_o(bresp_o),
    .bvalid_o(bvalid_o), .bready_i(bready_i), .araddr_i(araddr_i), .arprot_i(3'h0),
    .arvalid_i(arvalid_i), .arready_o(arready_o), .rdata_o(rdata_o), .rresp_o(rresp_o),
    .rvalid_o(rvalid_o), .rready_i(rready_i));

  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH time=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic state(input logic [7:0] e);
    @(negedge clk_i);
    chk(flags_o, e);
    chk(cond_o, {e[CARRY_BIT], e[OVF_BIT], e[ZERO_BIT], e[SIGN_BIT]});
  endtask

  task automatic alu(input alu_op_t op, input logic wc, input logic [7:0] a, b,
                     input logic so, input logic [1:0] m, v);
    alu_req_t q;
    q = '{valid:1'b1, op:op, with_carry:wc, a:a, b:b, shift_out:so, user_mask:m, user_val:v};
    @(posedge clk_i);
    alu_i <= q;
    @(posedge clk_i);
    alu_i <= '0;
  endtask

  task automatic axw(input logic [7:0] ad, input logic [31:0] d, input logic [3:0] s,
                     output logic [1:0] r);
    bit aw, w, done;
    r = 'x;
    done = 1'b0;
    @(posedge clk_i);
    awaddr_i <= ad;
    wdata_i <= d;
    wstrb_i <= s;
    awvalid_i <= 1'b1;
    wvalid_i <= 1'b1;
    bready_i <= 1'b1;
    for (int n = 0; n < 100 && !done; n++) begin
      @(negedge clk_i);
      aw = awvalid_i && awready_o;
      w = wvalid_i && wready_o;
      done = bvalid_o && bready_i;
      if (done) r = bresp_o;
      @(posedge clk_i);
      if (aw) awvalid_i <= 1'b0;
      if (w) wvalid_i <= 1'b0;
      if (done) bready_i <= 1'b0;
    end
  endtask

  task automatic axr(input logic [7:0] ad, output logic [31:0] d, output logic [1:0] r);
    bit a, done;
    d = 'x;
    r = 'x;
    done = 1'b0;
    @(posedge clk_i);
    araddr_i <= ad;
    arvalid_i <= 1'b1;
    rready_i <= 1'b1;
    for (int n = 0; n < 100 && !done; n++) begin
      @(negedge clk_i);
      a = arvalid_i && arready_o;
      done = rvalid_o && rready_i;
      if (done) begin
        d = rdata_o;
        r = rresp_o;
      end
      @(posedge clk_i);
      if (a) arvalid_i <= 1'b0;
      if (done) rready_i <= 1'b0;
    end
  endtask

  task automatic t_arith;
    alu(OP_ADD, 1'b0, 8'hff, 8'h01, 1'b0, 2'h0, 2'h0);
    state(8'hc4);
    chk(result_o, 8'h00);
    alu(OP_ADD, 1'b1, 8'h01, 8'h01, 1'b0, 2'h0, 2'h0);
    state(8'h00);
    chk(result_o, 8'h03);
    alu(OP_ADD, 1'b0, 8'h7f, 8'h01, 1'b0, 2'h0, 2'h0);
    state(8'h34);
    alu(OP_SUB, 1'b0, 8'h00, 8'h01, 1'b0, 2'h0, 2'h0);
    state(8'hac);
    chk(result_o, 8'hff);
    alu(OP_SUB, 1'b1, 8'h80, 8'h01, 1'b0, 2'h0, 2'h0);
    state(8'h1c);
    chk(result_o, 8'h7e);
  endtask

  task automatic t_user_shift;
    alu(OP_USER, 1'b0, 8'h00, 8'h00, 1'b0, 2'b11, 2'b10);
    state(8'h1e);
    alu(OP_USER, 1'b0, 8'h00, 8'h00, 1'b0, 2'b01, 2'b01);
    state(8'h1f);
    alu(OP_LOGIC, 1'b0, 8'h00, 8'h00, 1'b0, 2'h0, 2'h0);
    state(8'h4f);
    alu(OP_LOGIC, 1'b0, 8'hc3, 8'h00, 1'b0, 2'h0, 2'h0);
    state(8'h2f);
    alu(OP_SHIFT, 1'b0, 8'h80, 8'h00, 1'b1, 2'h0, 2'h0);
    state(8'haf);
    alu(OP_SHIFT, 1'b0, 8'h01, 8'h00, 1'b0, 2'h0, 2'h0);
    state(8'h0f);
  endtask

  task automatic t_bus;
    axw(FLAGS_ADDR, 32'h0000005a, 4'hf, rs);
    chk(rs, RESP_OKAY);
    state(8'h5a);
    axw(8'hf8, 32'h000000ff, 4'hf, rs);
    chk(rs, RESP_SLVERR);
    axr(8'hf8, rd, rs);
    chk({rd, rs}, {32'h0, RESP_SLVERR});
    axw(FLAGS_ADDR, 32'h000000ff, 4'h0, rs);
    chk(rs, RESP_OKAY);
    state(8'h5a);
    axw(FLAGS_ADDR, 32'hffffffff, 4'hf, rs);
    axr(FLAGS_ADDR, rd, rs);
    chk({rd, rs}, {32'h000000ff, RESP_OKAY});
  endtask

  task automatic t_reset;
    axr(FLAGS_ADDR, rd, rs);
    chk({rd, rs}, {24'h0, FLAGS_RESET, RESP_OKAY});
    state(FLAGS_RESET);
  endtask

  task automatic t_stall;
    @(posedge clk_i);
    awaddr_i  <= FLAGS_ADDR;
    wdata_i   <= 32'h0000_0033;
    wstrb_i   <= 4'h1;
    awvalid_i <= 1'b1;
    wvalid_i  <= 1'b1;
    do @(negedge clk_i); while (!(awready_o && wready_o));
    @(posedge clk_i);
    awvalid_i <= 1'b0;
    wvalid_i  <= 1'b0;
    do @(negedge clk_i); while (!bvalid_o);
    repeat (3) begin
      @(negedge clk_i);
      chk({bvalid_o, bresp_o}, {1'b1, RESP_OKAY});
    end
    @(posedge clk_i);
    bready_i <= 1'b1;
    @(posedge clk_i);
    bready_i <= 1'b0;
    state(8'h33);
    chk(bvalid_o, 1'b0);
    @(posedge clk_i);
    araddr_i  <= FLAGS_ADDR;
    arvalid_i <= 1'b1;
    do @(negedge clk_i); while (!arready_o);
    @(posedge clk_i);
    arvalid_i <= 1'b0;
    repeat (2) begin
      @(negedge clk_i);
      chk({rvalid_o, rresp_o, rdata_o}, {1'b1, RESP_OKAY, 32'h0000_0033});
    end
    @(posedge clk_i);
    rready_i <= 1'b1;
    @(posedge clk_i);
    rready_i <= 1'b0;
    @(negedge clk_i);
    chk({rvalid_o, arready_o}, 2'b01);
  endtask

  task automatic results;
    $display("errors=%0d comparisons=%0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  initial begin
    repeat (5000) @(posedge clk_i);
    errors++;
    results();
  end

  initial begin
    {awvalid_i, wvalid_i, bready_i, arvalid_i, rready_i} = '0;
    {awaddr_i, araddr_i, wdata_i, wstrb_i} = '0;
    alu_i = '0;
    rstn_i = 1'b0;
    repeat (8) @(posedge clk_i);
    rstn_i <= 1'b1;
    t_reset();
    t_arith();
    t_user_shift();
    t_bus();
    t_stall();
    results();
  end
endmodule
